// ---- include/csbu_params.svh ----
`ifndef CSBU_PARAMS_SVH
`define CSBU_PARAMS_SVH

// Program counter width in bits.
`define CSBU_PC_W 16

// Flag positions inside the flag register.
`define CSBU_FLAG_C 3'd0
`define CSBU_FLAG_Z 3'd1
`define CSBU_FLAG_N 3'd2

// Program counter steps in words.
`define CSBU_STEP_SEQ      16'h0001
`define CSBU_STEP_SKIP_ONE 16'h0002
`define CSBU_STEP_SKIP_TWO 16'h0003

// Execution cycle counts.
`define CSBU_CYC_ONE   2'h1
`define CSBU_CYC_TWO   2'h2
`define CSBU_CYC_THREE 2'h3

// Reset values of the state register.
`define CSBU_RST_PC    16'h0000
`define CSBU_RST_CYC   2'h0

`endif

// ---- include/csbu_pkg.sv ----
`include "csbu_params.svh"

package csbu_pkg;

  // Operations handed over by the instruction decoder.
  typedef enum logic [3:0] {
    CSBU_SKIP_IF_REG_BIT_CLEAR    = 4'h0,
    CSBU_SKIP_IF_REG_BIT_SET      = 4'h1,
    CSBU_SKIP_IF_IO_BIT_CLEAR     = 4'h2,
    CSBU_SKIP_IF_IO_BIT_SET       = 4'h3,
    CSBU_BRANCH_IF_FLAG_SET       = 4'h4,
    CSBU_BRANCH_IF_FLAG_CLEAR     = 4'h5,
    CSBU_BRANCH_IF_EQUAL          = 4'h6,
    CSBU_BRANCH_IF_NOT_EQUAL      = 4'h7,
    CSBU_BRANCH_IF_CARRY_SET      = 4'h8,
    CSBU_BRANCH_IF_CARRY_CLEAR    = 4'h9,
    CSBU_BRANCH_IF_SAME_OR_HIGHER = 4'ha,
    CSBU_BRANCH_IF_LOWER          = 4'hb,
    CSBU_BRANCH_IF_MINUS          = 4'hc,
    CSBU_BRANCH_IF_PLUS           = 4'hd
  } csbu_op_t;

  // Sequencer states, Gray coded along idle, stall, last.
  typedef enum logic [1:0] {
    CSBU_IDLE  = 2'b00,
    CSBU_STALL = 2'b01,
    CSBU_LAST  = 2'b11
  } csbu_state_t;

  // Complete state of the unit.
  typedef struct packed {
    csbu_state_t             state;
    logic                    cnt;
    logic                    taken;
    logic [`CSBU_PC_W-1:0]   pc_next;
    logic [1:0]              cycles;
  } csbu_regs_t;

endpackage

// ---- hw/csbu_bit_test.sv ----
`timescale 1ns/100ps
`default_nettype none

// Compares one selected bit of a word against the wanted level.
module csbu_bit_test #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]         data,
  input  wire logic [$clog2(W)-1:0] index,
  input  wire logic                 want_set,
  output logic                      match
);

  // Pure selection, no state, so the result is valid in the decode cycle.
  assign match = (data[index] == want_set);

endmodule

`default_nettype wire

// ---- hw/csbu_core.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "csbu_params.svh"

module csbu_core
  import csbu_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  instr_valid,
  input  wire csbu_op_t              instr_op,
  input  wire logic [2:0]            bit_index,
  input  wire logic [7:0]            reg_data,
  input  wire logic [7:0]            io_data,
  input  wire logic [7:0]            flag_register,
  input  wire logic [6:0]            rel_offset,
  input  wire logic [`CSBU_PC_W-1:0] pc_current,
  input  wire logic                  next_two_word,
  output logic                       busy,
  output logic                       done,
  output logic                       pc_load,
  output logic [`CSBU_PC_W-1:0]      pc_next,
  output logic                       taken,
  output logic [1:0]                 cycles,
  output logic                       flag_write_en
);

  csbu_regs_t            q;
  csbu_regs_t            d;
  logic                  accept;
  logic                  is_skip;
  logic                  reg_hit;
  logic                  io_hit;
  logic                  flag_hit;
  logic [2:0]            flag_sel;
  logic                  flag_want;
  logic                  cond;
  logic [`CSBU_PC_W-1:0] pc_seq;
  logic [`CSBU_PC_W-1:0] pc_skip;
  logic [`CSBU_PC_W-1:0] pc_branch;
  logic [1:0]            cyc_new;

  // Decoder may hand over a new instruction only while no stall is running.
  assign busy   = (q.state == CSBU_STALL);
  assign accept = instr_valid && !busy;
  assign is_skip = (instr_op == CSBU_SKIP_IF_REG_BIT_CLEAR) || (instr_op == CSBU_SKIP_IF_REG_BIT_SET) ||
                   (instr_op == CSBU_SKIP_IF_IO_BIT_CLEAR) || (instr_op == CSBU_SKIP_IF_IO_BIT_SET);

  // Flag index and wanted level; fixed-flag forms override the operand index.
  always_comb begin
    flag_sel  = bit_index;
    flag_want = 1'b1;
    case (instr_op)
      CSBU_BRANCH_IF_FLAG_SET: begin
        flag_want = 1'b1;
      end
      CSBU_BRANCH_IF_FLAG_CLEAR: begin
        flag_want = 1'b0;
      end
      CSBU_BRANCH_IF_EQUAL: begin
        flag_sel  = `CSBU_FLAG_Z;
        flag_want = 1'b1;
      end
      CSBU_BRANCH_IF_NOT_EQUAL: begin
        flag_sel  = `CSBU_FLAG_Z;
        flag_want = 1'b0;
      end
      CSBU_BRANCH_IF_CARRY_SET, CSBU_BRANCH_IF_LOWER: begin
        flag_sel  = `CSBU_FLAG_C;
        flag_want = 1'b1;
      end
      CSBU_BRANCH_IF_CARRY_CLEAR, CSBU_BRANCH_IF_SAME_OR_HIGHER: begin
        flag_sel  = `CSBU_FLAG_C;
        flag_want = 1'b0;
      end
      CSBU_BRANCH_IF_MINUS: begin
        flag_sel  = `CSBU_FLAG_N;
        flag_want = 1'b1;
      end
      CSBU_BRANCH_IF_PLUS: begin
        flag_sel  = `CSBU_FLAG_N;
        flag_want = 1'b0;
      end
      default: begin
        flag_sel  = bit_index;
        flag_want = 1'b1;
      end
    endcase
  end

  // Bit tests; the clear forms use the low bit of the op as the wanted level.
  csbu_bit_test #(.W(8)) u_reg_test (
    .data     (reg_data),
    .index    (bit_index),
    .want_set (instr_op[0]),
    .match    (reg_hit)
  );

  csbu_bit_test #(.W(8)) u_io_test (
    .data     (io_data),
    .index    (bit_index),
    .want_set (instr_op[0]),
    .match    (io_hit)
  );

  csbu_bit_test #(.W(8)) u_flag_test (
    .data     (flag_register),
    .index    (flag_sel),
    .want_set (flag_want),
    .match    (flag_hit)
  );

  // Condition by instruction class.
  always_comb begin
    case (instr_op)
      CSBU_SKIP_IF_REG_BIT_CLEAR, CSBU_SKIP_IF_REG_BIT_SET: cond = reg_hit;
      CSBU_SKIP_IF_IO_BIT_CLEAR, CSBU_SKIP_IF_IO_BIT_SET:   cond = io_hit;
      default:                                              cond = flag_hit;
    endcase
  end

  // Candidate targets; the offset is a signed word count.
  assign pc_seq    = pc_current + `CSBU_STEP_SEQ;
  assign pc_skip   = pc_current + (next_two_word ? `CSBU_STEP_SKIP_TWO : `CSBU_STEP_SKIP_ONE);
  assign pc_branch = pc_current + {{(`CSBU_PC_W-7){rel_offset[6]}}, rel_offset} + `CSBU_STEP_SEQ;

  // Cycle cost: one when not taken, two for a branch or short skip, three for a long skip.
  always_comb begin
    if (!cond) begin
      cyc_new = `CSBU_CYC_ONE;
    end else if (is_skip && next_two_word) begin
      cyc_new = `CSBU_CYC_THREE;
    end else begin
      cyc_new = `CSBU_CYC_TWO;
    end
  end

  // Sequencer. The result is latched at accept so it is stable through the stall.
  always_comb begin
    d = q;
    case (q.state)
      CSBU_IDLE, CSBU_LAST: begin
        d.state = CSBU_IDLE;
        if (accept) begin
          d.taken   = cond;
          d.cycles  = cyc_new;
          d.pc_next = !cond ? pc_seq : (is_skip ? pc_skip : pc_branch);
          d.state   = (cyc_new == `CSBU_CYC_ONE) ? CSBU_LAST : CSBU_STALL;
          d.cnt     = (cyc_new == `CSBU_CYC_THREE);
        end
      end
      CSBU_STALL: begin
        if (q.cnt) begin
          d.cnt = 1'b0;
        end else begin
          d.state = CSBU_LAST;
        end
      end
      default: begin
        d.state = CSBU_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '{state: CSBU_IDLE, cnt: 1'b0, taken: 1'b0, pc_next: `CSBU_RST_PC, cycles: `CSBU_RST_CYC};
    end else begin
      q <= d;
    end
  end

  // Completion is a one-cycle pulse; the counter is loaded only on a taken flow change.
  assign done          = (q.state == CSBU_LAST);
  assign pc_load       = done && q.taken;
  assign pc_next       = q.pc_next;
  assign taken         = q.taken;
  assign cycles        = q.cycles;
  // This unit never owns the flag write port, so flags survive every outcome.
  assign flag_write_en = 1'b0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_long_skip;
    accept && is_skip && cond && next_two_word;
  endsequence

  sequence s_three_cycles;
    busy ##1 busy ##1 (done && cycles == 2'h3);
  endsequence

  chk_skip_reg_clear: assert property (accept && instr_op == CSBU_SKIP_IF_REG_BIT_CLEAR && !reg_data[bit_index]
    |=> taken && pc_next == $past(pc_current) + ($past(next_two_word) ? 16'h0003 : 16'h0002))
    else $error("register bit clear skip wrong");
  chk_skip_reg_set: assert property (accept && instr_op == CSBU_SKIP_IF_REG_BIT_SET && reg_data[bit_index]
    |=> taken && pc_next == $past(pc_current) + ($past(next_two_word) ? 16'h0003 : 16'h0002))
    else $error("register bit set skip wrong");
  chk_skip_io_clear: assert property (accept && instr_op == CSBU_SKIP_IF_IO_BIT_CLEAR
    |=> taken == !$past(io_data[bit_index]))
    else $error("io bit clear skip decision wrong");
  chk_skip_io_set: assert property (accept && instr_op == CSBU_SKIP_IF_IO_BIT_SET && !io_data[bit_index]
    |=> !taken && pc_next == $past(pc_current) + 16'h0001 && done && cycles == 2'h1)
    else $error("io bit set skip taken wrongly");
  chk_branch_flag_set: assert property (accept && instr_op == CSBU_BRANCH_IF_FLAG_SET && flag_register[bit_index]
    |=> busy ##1 (pc_load && pc_next == $past(pc_branch, 2)))
    else $error("flag set branch target or timing wrong");
  chk_branch_flag_clear: assert property (accept && instr_op == CSBU_BRANCH_IF_FLAG_CLEAR
    |=> taken == !$past(flag_register[bit_index]))
    else $error("flag clear branch decision wrong");
  chk_equal_forms: assert property (accept && instr_op == CSBU_BRANCH_IF_NOT_EQUAL
    |=> taken == !$past(flag_register[1]))
    else $error("not equal branch uses wrong flag");
  chk_carry_forms: assert property (accept && instr_op == CSBU_BRANCH_IF_CARRY_SET
    |=> taken == $past(flag_register[0]))
    else $error("carry set branch uses wrong flag");
  chk_unsigned_forms: assert property (accept && instr_op == CSBU_BRANCH_IF_SAME_OR_HIGHER
    |=> taken == !$past(flag_register[0]))
    else $error("same or higher branch uses wrong flag");
  chk_sign_forms: assert property (accept && instr_op == CSBU_BRANCH_IF_MINUS
    |=> taken == $past(flag_register[2]))
    else $error("minus branch uses wrong flag");
  chk_flags_kept: assert property (accept |-> !flag_write_en [*3])
    else $error("flag write during skip or branch");
  chk_skip_latency: assert property (s_long_skip |=> s_three_cycles)
    else $error("long skip does not take three cycles");

endmodule

`default_nettype wire

// ---- dv/tb_conditional_skip_branch_unit.sv ----
`timescale 1ns/100ps
`default_nettype none

`include "csbu_params.svh"

// Self-checking bench for the skip and conditional branch unit.
module tb_conditional_skip_branch_unit
  import csbu_pkg::*;
;
  logic                  sys_clk;
  logic                  reset;
  logic                  instr_valid;
  csbu_op_t              instr_op;
  logic [2:0]            bit_index;
  logic [7:0]            reg_data;
  logic [7:0]            io_data;
  logic [7:0]            flag_register;
  logic [6:0]            rel_offset;
  logic [`CSBU_PC_W-1:0] pc_current;
  logic                  next_two_word;
  logic                  busy;
  logic                  done;
  logic                  pc_load;
  logic [`CSBU_PC_W-1:0] pc_next;
  logic                  taken;
  logic [1:0]            cycles;
  logic                  flag_write_en;
  int                    fails;
  int                    checks_done;

  csbu_core i_csbu_core (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .instr_valid   (instr_valid),
    .instr_op      (instr_op),
    .bit_index     (bit_index),
    .reg_data      (reg_data),
    .io_data       (io_data),
    .flag_register (flag_register),
    .rel_offset    (rel_offset),
    .pc_current    (pc_current),
    .next_two_word (next_two_word),
    .busy          (busy),
    .done          (done),
    .pc_load       (pc_load),
    .pc_next       (pc_next),
    .taken         (taken),
    .cycles        (cycles),
    .flag_write_en (flag_write_en)
  );

  // 25 MHz core clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Closing report; also the landing place of a wait that runs out.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Four-state compare so an unknown output never counts as a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Condition that the operation tests, worked out independently of the design.
  function automatic logic exp_cond(csbu_op_t op, logic [2:0] b, logic [7:0] rd, logic [7:0] io, logic [7:0] fr);
    case (op)
      CSBU_SKIP_IF_REG_BIT_CLEAR:    return !rd[b];
      CSBU_SKIP_IF_REG_BIT_SET:      return rd[b];
      CSBU_SKIP_IF_IO_BIT_CLEAR:     return !io[b];
      CSBU_SKIP_IF_IO_BIT_SET:       return io[b];
      CSBU_BRANCH_IF_FLAG_SET:       return fr[b];
      CSBU_BRANCH_IF_FLAG_CLEAR:     return !fr[b];
      CSBU_BRANCH_IF_EQUAL:          return fr[1];
      CSBU_BRANCH_IF_NOT_EQUAL:      return !fr[1];
      CSBU_BRANCH_IF_CARRY_SET:      return fr[0];
      CSBU_BRANCH_IF_CARRY_CLEAR:    return !fr[0];
      CSBU_BRANCH_IF_SAME_OR_HIGHER: return !fr[0];
      CSBU_BRANCH_IF_LOWER:          return fr[0];
      CSBU_BRANCH_IF_MINUS:          return fr[2];
      default:                       return !fr[2];
    endcase
  endfunction

  // Presents one instruction, then judges target, cost and completion pulse.
  task automatic run(input csbu_op_t op, input logic [2:0] b, input logic [7:0] rd, input logic [7:0] io,
                     input logic [7:0] fr, input logic [6:0] k, input logic [15:0] pc, input logic tw);
    logic        t;
    logic        skip;
    logic [15:0] tgt;
    logic [1:0]  cy;
    int          n;
    t = exp_cond(op, b, rd, io, fr);
    skip = (op <= CSBU_SKIP_IF_IO_BIT_SET);
    tgt = !t ? pc + 16'h0001 : skip ? pc + (tw ? 16'h0003 : 16'h0002) : pc + {{9{k[6]}}, k} + 16'h0001;
    cy = !t ? 2'h1 : (skip && tw) ? 2'h3 : 2'h2;
    @(posedge sys_clk);
    instr_op <= op;
    bit_index <= b;
    reg_data <= rd;
    io_data <= io;
    flag_register <= fr;
    rel_offset <= k;
    pc_current <= pc;
    next_two_word <= tw;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk(taken, t);
    chk(pc_next, tgt);
    chk(cycles, cy);
    chk(busy, cy != 2'h1);
    n = 1;
    while (done !== 1'b1 && n < 6) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n, cy);
    chk(pc_load, t);
    chk(flag_write_en, 1'b0);
    if (done !== 1'b1) begin
      print_verdict();
    end
    // A second load pulse would move the program counter twice, so both pulses must drop.
    @(posedge sys_clk);
    #1;
    chk({done, pc_load}, 2'b00);
  endtask

  // Outputs must sit at their idle values straight after reset.
  task automatic t_reset();
    chk({busy, done, pc_load, taken, cycles, flag_write_en}, 32'h0);
    chk(pc_next, 16'h0000);
  endtask

  // Every skip form, both bit levels, edge bit positions, both skipped lengths.
  task automatic t_skips();
    for (int op = 0; op < 4; op++) begin
      for (int v = 0; v < 4; v++) begin
        run(csbu_op_t'(op), v[0] ? 3'h7 : 3'h0, v[1] ? 8'h81 : 8'h7e, v[1] ? 8'h7e : 8'h81, 8'hff, 7'h3f,
            16'h1234, v[0]);
      end
    end
  endtask

  // Selected-flag branches over every flag position, the taken ones with a negative offset.
  task automatic t_flag_branches();
    for (int s = 0; s < 8; s++) begin
      run(CSBU_BRANCH_IF_FLAG_SET, s[2:0], 8'h00, 8'h00, 8'h01 << s, 7'h40, 16'h0010, 1'b0);
      run(CSBU_BRANCH_IF_FLAG_SET, s[2:0], 8'h00, 8'h00, ~(8'h01 << s), 7'h7f, 16'h0010, 1'b0);
      run(CSBU_BRANCH_IF_FLAG_CLEAR, s[2:0], 8'h00, 8'h00, ~(8'h01 << s), 7'h40, 16'h0010, 1'b0);
      run(CSBU_BRANCH_IF_FLAG_CLEAR, s[2:0], 8'h00, 8'h00, 8'h01 << s, 7'h01, 16'h0010, 1'b0);
    end
  endtask

  // Named branches against each single flag and none, including a wrapping target.
  task automatic t_named_branches();
    logic [7:0] fr_set [4];
    fr_set = '{8'h00, 8'h01, 8'h02, 8'h04};
    for (int op = 6; op < 14; op++) begin
      for (int f = 0; f < 4; f++) begin
        run(csbu_op_t'(op), 3'h0, 8'h00, 8'h00, fr_set[f], 7'h3f, 16'hffe0, 1'b0);
      end
    end
  endtask

  // Main sequence: idle inputs, ten reset cycles, then the scenarios.
  initial begin
    fails = 0;
    checks_done = 0;
    reset = 1'b1;
    instr_valid = 1'b0;
    instr_op = CSBU_SKIP_IF_REG_BIT_CLEAR;
    bit_index = 3'h0;
    reg_data = 8'h00;
    io_data = 8'h00;
    flag_register = 8'h00;
    rel_offset = 7'h00;
    pc_current = 16'h0000;
    next_two_word = 1'b0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    t_reset();
    t_skips();
    t_flag_branches();
    t_named_branches();
    print_verdict();
  end
endmodule

`default_nettype wire
